// file: src/dpau_pkg.sv
// Constants shared by the dual process alarm unit
package dpau_pkg;
  localparam int VW = 16;
  localparam int AW = 8;
  localparam int CW = 27;
  // Key-hold timing
  localparam int CLK_HZ = 20_000_000;
  localparam int HOLD_S = 5;
  localparam int HOLD_CYC = HOLD_S * CLK_HZ;
  // Register offsets
  localparam logic [AW-1:0] OFS_CFG1 = 8'h00;
  localparam logic [AW-1:0] OFS_CFG2 = 8'h04;
  localparam logic [AW-1:0] OFS_LO1 = 8'h08;
  localparam logic [AW-1:0] OFS_HI1 = 8'h0C;
  localparam logic [AW-1:0] OFS_LO2 = 8'h10;
  localparam logic [AW-1:0] OFS_HI2 = 8'h14;
  localparam logic [AW-1:0] OFS_SETP = 8'h18;
  localparam logic [AW-1:0] OFS_RBOT = 8'h1C;
  localparam logic [AW-1:0] OFS_RTOP = 8'h20;
  localparam logic [AW-1:0] OFS_FILT = 8'h24;
  localparam logic [AW-1:0] OFS_STAT = 8'h28;
  localparam logic [AW-1:0] OFS_PV = 8'h2C;
  // Channel configuration fields
  localparam int CFG_FN = 0;
  localparam int CFG_OFS = 2;
  localparam int CFG_MAN = 3;
  localparam int CFG_RARM = 4;
  localparam int CFG_INH = 5;
  localparam int CFG_OPEN = 6;
  localparam int CFG_LINV = 7;
  // Function codes
  localparam logic [1:0] FN_OFF = 2'h0;
  localparam logic [1:0] FN_LO = 2'h1;
  localparam logic [1:0] FN_HI = 2'h2;
  localparam logic [1:0] FN_BOTH = 2'h3;
  // Reset values
  localparam logic [7:0] CFG1_RST = 8'h02;
  localparam logic [7:0] CFG2_RST = 8'h01;
  localparam logic [VW-1:0] LO1_RST = 16'h0000;
  localparam logic [VW-1:0] HI1_RST = 16'h00E7;
  localparam logic [VW-1:0] LO2_RST = 16'h0014;
  localparam logic [VW-1:0] HI2_RST = 16'h0000;
  localparam logic [VW-1:0] SETP_RST = 16'h00E7;
  localparam logic [VW-1:0] RBOT_RST = 16'hFFC7;
  localparam logic [VW-1:0] RTOP_RST = 16'h00E7;
  localparam logic [6:0] FILT_RST = 7'h03;
  localparam logic [6:0] FILT_MAX = 7'h63;
endpackage : dpau_pkg

// file: src/dpau_core.sv
// Dual process alarm channels with register port and key timers
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps

// Notes on behaviour
// - Absolute type trips only beyond the programmed limit, not at the limit itself.
// - Offset type trips at pump 1 on set point plus signed offset.
// - Offset thresholds follow every change of the set point.
// - Limits, offsets and values are integer counts of the last digit.
// - Re-arm plus manual reset clears a latch on restore if no condition.
// - Inhibit suppresses the alarm after power-up until a non-alarm value.
// - Index and enter held five seconds re-arm inhibit like power-up.
// - Function picks off, low, high or both; both share one relay.
// - A disabled channel never asserts; output state and lamp inversion still act.
// - Channel one resets to high-only, channel two to low-only.
// - Alarm type resets to absolute; offset type may be chosen.
// - Absolute limits are held between range bottom and range top.
// - Auto reset follows; manual latches until index+down held 5 s.
// - Output state picks contact closing or opening on alarm.
// - Lamp lit when contact closed, or when open if inverted.
// - Re-arm and inhibit are per channel and default off.
// - Process value is smoothed, filter off or 1 to 99, default 3.
// - Self-check failure forces both alarms and set points inactive.
// - Host timeout forces both alarms inactive; set points stay.
module dpau_core #(
  parameter int HOLD_CYCLES = dpau_pkg::HOLD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [dpau_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Process value samples
  input wire logic [dpau_pkg::VW-1:0] pv_in,
  input wire logic pv_valid,
  // Front panel keys, high while pressed
  input wire logic key_index,
  input wire logic key_enter,
  input wire logic key_down,
  // System status
  input wire logic self_check_failure,
  input wire logic host_timeout_indication,
  input wire logic power_restored,
  // Set point requests from pump control
  input wire logic [1:0] sp_req,
  // Relay contacts (1 = closed), lamps and set point outputs
  output logic [1:0] alarm_contact,
  output logic [1:0] alarm_lamp,
  output logic [1:0] setpoint_out
);
  import dpau_pkg::*;

  typedef struct packed {
    logic [1:0][7:0] cfg;
    logic [3:0][VW-1:0] lim;
    logic [VW-1:0] setp;
    logic [VW-1:0] rbot;
    logic [VW-1:0] rtop;
    logic [VW-1:0] pvf;
    logic [6:0] filt;
    logic pv_init;
    logic [1:0] alm;
    logic [1:0] inh;
    logic [1:0] contact;
    logic [1:0] lamp;
    logic [1:0] sp;
    logic [CW-1:0] cnt_rearm;
    logic [CW-1:0] cnt_ack;
    logic [31:0] rdata;
  } dpau_state_t;

  localparam dpau_state_t ST_RST = '{
    cfg: {CFG2_RST, CFG1_RST},
    lim: {HI2_RST, LO2_RST, HI1_RST, LO1_RST},
    setp: SETP_RST, rbot: RBOT_RST, rtop: RTOP_RST,
    pvf: '0, filt: FILT_RST, pv_init: 1'b0,
    alm: 2'h0, inh: 2'h3, contact: 2'h0, lamp: 2'h0, sp: 2'h0,
    cnt_rearm: '0, cnt_ack: '0, rdata: '0};

  dpau_state_t s_reg;
  dpau_state_t s_next;
  logic rst_meta;
  logic rst_n;

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Signed clamp of an absolute limit into the input range
  function automatic logic signed [VW:0] clampv(
    input logic [VW-1:0] v,
    input logic [VW-1:0] b,
    input logic [VW-1:0] t
  );
    logic signed [VW:0] sv;
    sv = $signed({v[VW-1], v});
    if (sv < $signed({b[VW-1], b}))
      sv = $signed({b[VW-1], b});
    else if (sv > $signed({t[VW-1], t}))
      sv = $signed({t[VW-1], t});
    return sv;
  endfunction : clampv

  logic signed [VW:0] thr [4];
  logic signed [VW:0] dif;
  logic signed [VW:0] dvs;
  logic signed [VW:0] quo;
  logic [VW-1:0] nf;
  logic [1:0] cond_new;
  logic [1:0] cond_now;
  logic [1:0] raw;
  logic [1:0] eff;
  logic rearm_pulse;
  logic ack_pulse;

  // Next state of the whole block
  always_comb
  begin
    s_next = s_reg;
    // Register writes; limits are kept as counts
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_CFG1: s_next.cfg[0] = reg_wdata[7:0];
        OFS_CFG2: s_next.cfg[1] = reg_wdata[7:0];
        OFS_LO1: s_next.lim[0] = reg_wdata[VW-1:0];
        OFS_HI1: s_next.lim[1] = reg_wdata[VW-1:0];
        OFS_LO2: s_next.lim[2] = reg_wdata[VW-1:0];
        OFS_HI2: s_next.lim[3] = reg_wdata[VW-1:0];
        OFS_SETP: s_next.setp = reg_wdata[VW-1:0];
        OFS_RBOT: s_next.rbot = reg_wdata[VW-1:0];
        OFS_RTOP: s_next.rtop = reg_wdata[VW-1:0];
        // Oversized filter settings saturate at the top setting
        OFS_FILT: s_next.filt = (reg_wdata[6:0] > FILT_MAX) ?
                                FILT_MAX : reg_wdata[6:0];
        default: ;
      endcase
    end
    // Smoothing: step a fraction 1/(n+1) of the way to the sample
    dif = $signed({pv_in[VW-1], pv_in}) - $signed({s_reg.pvf[VW-1], s_reg.pvf});
    dvs = $signed({{(VW-6){1'b0}}, s_reg.filt}) + 17'sh00001;
    quo = dif / dvs;
    if (!s_reg.pv_init || s_reg.filt == 7'h00)
      nf = pv_in;
    else
      nf = s_reg.pvf + quo[VW-1:0];
    // Key hold timers restart as soon as either key drops
    rearm_pulse = 1'b0;
    ack_pulse = 1'b0;
    if (key_index && key_enter)
    begin
      if (s_reg.cnt_rearm != CW'(HOLD_CYCLES))
        s_next.cnt_rearm = s_reg.cnt_rearm + 1'b1;
      rearm_pulse = (s_reg.cnt_rearm == CW'(HOLD_CYCLES - 1));
    end
    else
      s_next.cnt_rearm = '0;
    if (key_index && key_down)
    begin
      if (s_reg.cnt_ack != CW'(HOLD_CYCLES))
        s_next.cnt_ack = s_reg.cnt_ack + 1'b1;
      ack_pulse = (s_reg.cnt_ack == CW'(HOLD_CYCLES - 1));
    end
    else
      s_next.cnt_ack = '0;
    if (pv_valid)
    begin
      s_next.pvf = nf;
      s_next.pv_init = 1'b1;
    end
    // Per channel thresholds, conditions and alarm state
    for (int c = 0; c < 2; c++)
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (s_reg.cfg[c][CFG_OFS])
          thr[2*c+k] = $signed({s_reg.setp[VW-1], s_reg.setp})
            + $signed({s_reg.lim[2*c+k][VW-1], s_reg.lim[2*c+k]});
        else
          thr[2*c+k] = clampv(s_reg.lim[2*c+k], s_reg.rbot,
                              s_reg.rtop);
      end
      // Low bit of function enables low, high bit enables high
      cond_new[c] =
        (s_reg.cfg[c][CFG_FN] && $signed({nf[VW-1], nf}) < thr[2*c])
        || (s_reg.cfg[c][CFG_FN+1]
            && $signed({nf[VW-1], nf}) > thr[2*c+1]);
      cond_now[c] =
        (s_reg.cfg[c][CFG_FN]
         && $signed({s_reg.pvf[VW-1], s_reg.pvf}) < thr[2*c])
        || (s_reg.cfg[c][CFG_FN+1]
            && $signed({s_reg.pvf[VW-1], s_reg.pvf}) > thr[2*c+1]);
      raw[c] = pv_valid && cond_new[c]
               && !(s_reg.inh[c] && s_reg.cfg[c][CFG_INH]);
      // A non-alarm sample lifts the inhibit
      if (pv_valid && !cond_new[c])
        s_next.inh[c] = 1'b0;
      // Key re-arm and power restore act as a fresh power-up
      if (rearm_pulse || power_restored)
        s_next.inh[c] = 1'b1;
      if (s_reg.cfg[c][CFG_MAN])
      begin
        // Manual: a new trip in the clearing cycle still latches
        s_next.alm[c] = s_reg.alm[c] | raw[c];
        if (ack_pulse && !raw[c])
          s_next.alm[c] = 1'b0;
        if (power_restored && s_reg.cfg[c][CFG_RARM] && !cond_now[c]
            && !raw[c])
          s_next.alm[c] = 1'b0;
      end
      else if (pv_valid)
        s_next.alm[c] = raw[c];
      if (s_reg.cfg[c][CFG_FN+:2] == FN_OFF)
        s_next.alm[c] = 1'b0;
      // Fault flags mask the alarm without clearing its latch
      eff[c] = s_next.alm[c] && !self_check_failure
               && !host_timeout_indication;
      s_next.contact[c] = eff[c] ^ s_reg.cfg[c][CFG_OPEN];
      s_next.lamp[c] = s_next.contact[c]
                       ^ s_reg.cfg[c][CFG_LINV];
    end
    s_next.sp = self_check_failure ? 2'h0 : sp_req;
    // Read data stands only in the cycle after the strobe
    s_next.rdata = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_CFG1: s_next.rdata = {24'h000000, s_reg.cfg[0]};
        OFS_CFG2: s_next.rdata = {24'h000000, s_reg.cfg[1]};
        OFS_LO1: s_next.rdata = {16'h0000, s_reg.lim[0]};
        OFS_HI1: s_next.rdata = {16'h0000, s_reg.lim[1]};
        OFS_LO2: s_next.rdata = {16'h0000, s_reg.lim[2]};
        OFS_HI2: s_next.rdata = {16'h0000, s_reg.lim[3]};
        OFS_SETP: s_next.rdata = {16'h0000, s_reg.setp};
        OFS_RBOT: s_next.rdata = {16'h0000, s_reg.rbot};
        OFS_RTOP: s_next.rdata = {16'h0000, s_reg.rtop};
        OFS_FILT: s_next.rdata = {25'h0000000, s_reg.filt};
        OFS_STAT: s_next.rdata = {22'h000000, s_reg.sp, s_reg.lamp,
                                  s_reg.contact, s_reg.inh, s_reg.alm};
        OFS_PV: s_next.rdata = {16'h0000, s_reg.pvf};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= ST_RST;
    else
      s_reg <= s_next;
  end

  assign reg_rdata = s_reg.rdata;
  assign alarm_contact = s_reg.contact;
  assign alarm_lamp = s_reg.lamp;
  assign setpoint_out = s_reg.sp;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_selfchk;
    self_check_failure |=> alarm_contact
      == {$past(s_reg.cfg[1][CFG_OPEN]), $past(s_reg.cfg[0][CFG_OPEN])}
      && setpoint_out == 2'h0;
  endproperty
  a_selfchk: assert property (p_selfchk)
    else $error("self check failure left an output active");

  property p_timeout;
    host_timeout_indication && !self_check_failure |=>
      setpoint_out == $past(sp_req) && s_reg.contact ==
      {$past(s_reg.cfg[1][CFG_OPEN]), $past(s_reg.cfg[0][CFG_OPEN])};
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("host timeout handling wrong");

  property p_disabled;
    s_reg.cfg[0][CFG_FN+:2] == FN_OFF |=> !s_reg.alm[0];
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled channel asserted");

  property p_lamp;
    ##1 alarm_lamp[0] == (alarm_contact[0] ^ $past(s_reg.cfg[0][CFG_LINV]));
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp does not match contact");

  property p_auto;
    pv_valid && !s_reg.cfg[0][CFG_MAN] && !s_reg.cfg[0][CFG_INH]
      && s_reg.cfg[0][CFG_FN+:2] == FN_HI && !s_reg.cfg[0][CFG_OFS]
      |=> s_reg.alm[0] == ($signed({s_reg.pvf[VW-1], s_reg.pvf})
          > clampv($past(s_reg.lim[1]), $past(s_reg.rbot),
                   $past(s_reg.rtop)));
  endproperty
  a_auto: assert property (p_auto)
    else $error("automatic alarm does not follow its condition");

  property p_latch;
    s_reg.cfg[0][CFG_MAN] && s_reg.alm[0] && !ack_pulse && !power_restored
      && s_reg.cfg[0][CFG_FN+:2] != FN_OFF && !reg_wr |=> s_reg.alm[0];
  endproperty
  a_latch: assert property (p_latch)
    else $error("manual alarm dropped without acknowledge");

  property p_rearm;
    key_index && key_enter && s_reg.cnt_rearm == CW'(HOLD_CYCLES - 1)
      && !pv_valid |=> s_reg.inh == 2'h3;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("key hold did not re-arm inhibit");

  property p_keyrel;
    !key_index ##1 key_index && key_down |-> s_reg.cnt_ack == '0;
  endproperty
  a_keyrel: assert property (p_keyrel)
    else $error("ack timer did not restart on release");

  property p_inhibit;
    s_reg.cfg[0][CFG_INH] && s_reg.inh[0] && !s_reg.cfg[0][CFG_MAN]
      && !reg_wr && pv_valid |=> !s_reg.alm[0];
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibited channel raised an alarm");

endmodule : dpau_core

// file: testbench/dpau_panel_model.sv
// Far-side model of the alarm relay contacts and front panel lamps
`timescale 1ns/10ps
module dpau_panel_model (
  // Drive from the alarm unit
  input wire logic [1:0] alarm_contact,
  input wire logic [1:0] alarm_lamp,
  // What the panel shows
  output logic [1:0] relay_closed,
  output logic [1:0] lamp_glow
);
  // Relays and lamps follow their drive; bounce is not modelled
  assign relay_closed = alarm_contact;
  assign lamp_glow = alarm_lamp;
endmodule : dpau_panel_model

// file: testbench/dpau_core_tb.sv
// Self-checking bench for the dual process alarm unit
`timescale 1ns/10ps
module dpau_core_tb;
  import dpau_pkg::*;
  // Short key hold so the timers finish quickly
  localparam int HOLD = 8;
  typedef struct {
    logic [15:0] cfg;
    logic [15:0] setp;
    logic [15:0] hi;
    logic [15:0] pv;
    logic [1:0] con;
    logic [1:0] lamp;
  } dpau_row_t;
  logic clk, nrst, reg_wr, reg_rd, pv_valid, pwr;
  logic key_index, key_enter, key_down;
  logic self_check_failure, host_timeout_indication;
  logic [AW-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [VW-1:0] pv_in;
  logic [1:0] sp_req, alarm_contact, alarm_lamp, setpoint_out;
  logic [1:0] relay_closed, lamp_glow;
  int errors, samples_checked, cycles;
  dpau_row_t rows [12];

  dpau_core #(.HOLD_CYCLES(HOLD)) u_dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pv_in(pv_in), .pv_valid(pv_valid), .key_index(key_index),
    .key_enter(key_enter), .key_down(key_down),
    .self_check_failure(self_check_failure),
    .host_timeout_indication(host_timeout_indication),
    .power_restored(pwr), .sp_req(sp_req), .alarm_contact(alarm_contact),
    .alarm_lamp(alarm_lamp), .setpoint_out(setpoint_out)
  );
  dpau_panel_model u_panel (
    .alarm_contact(alarm_contact), .alarm_lamp(alarm_lamp),
    .relay_closed(relay_closed), .lamp_glow(lamp_glow)
  );

  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge clk);
      cycles++;
      if (cycles == 20000)
      begin
        errors++;
        tally_and_finish();
      end
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Waits, then lets the edge's updates settle
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(logic [AW-1:0] a, logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= {16'h0000, v};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rchk(string nm, logic [AW-1:0] a, logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
  endtask : rchk

  task automatic smp(logic [15:0] v);
    @(posedge clk);
    pv_in <= v;
    pv_valid <= 1'b1;
    @(posedge clk);
    pv_valid <= 1'b0;
    cyc(2);
  endtask : smp

  task automatic keys(logic i, logic e, logic dn, int n);
    @(posedge clk);
    key_index <= i;
    key_enter <= e;
    key_down <= dn;
    repeat (n) @(posedge clk);
    key_index <= 1'b0;
    key_enter <= 1'b0;
    key_down <= 1'b0;
    cyc(2);
  endtask : keys

  initial
  begin
    // Rows: ch1 config, set point, high limit, sample, contacts, lamps
    rows = '{
      '{16'h02, 16'hE7, 16'hE7, 16'hE8, 2'b01, 2'b01},
      '{16'h02, 16'hE7, 16'hE7, 16'hE7, 2'b00, 2'b00},
      '{16'h02, 16'hE7, 16'hE7, 16'h13, 2'b10, 2'b10},
      '{16'h06, 16'h64, 16'h05, 16'h6A, 2'b01, 2'b01},
      '{16'h06, 16'h64, 16'h05, 16'h69, 2'b00, 2'b00},
      '{16'h06, 16'h70, 16'h05, 16'h6A, 2'b00, 2'b00},
      '{16'h42, 16'hE7, 16'hE7, 16'hE8, 2'b00, 2'b00},
      '{16'h42, 16'hE7, 16'hE7, 16'h20, 2'b01, 2'b01},
      '{16'h82, 16'hE7, 16'hE7, 16'h20, 2'b00, 2'b01},
      '{16'h3C, 16'hE7, 16'hE7, 16'h7FFF, 2'b00, 2'b00},
      '{16'h03, 16'hE7, 16'hE7, 16'h0F, 2'b11, 2'b11},
      '{16'h02, 16'hE7, 16'h1000, 16'hE8, 2'b01, 2'b01}
    };
    errors = 0;
    samples_checked = 0;
    {nrst, reg_wr, reg_rd, pv_valid, pwr, key_index, key_enter} = '0;
    {key_down, self_check_failure, host_timeout_indication} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    pv_in = '0;
    sp_req = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    cyc(3);
    // Defaults after reset, unmapped place reads zero
    chk("contact", relay_closed, 2'b00);
    chk("lamp", lamp_glow, 2'b00);
    rchk("cfg1", OFS_CFG1, 32'h02);
    rchk("cfg2", OFS_CFG2, 32'h01);
    rchk("filter", OFS_FILT, 32'h03);
    rchk("unmapped", 8'h30, 32'h0);
    $display("reset test done");
    wr(OFS_FILT, 16'h0);
    wr(OFS_LO1, 16'h10);
    foreach (rows[i])
    begin
      wr(OFS_CFG1, rows[i].cfg);
      wr(OFS_SETP, rows[i].setp);
      wr(OFS_HI1, rows[i].hi);
      smp(rows[i].pv);
      chk("contact", relay_closed, rows[i].con);
      chk("lamp", lamp_glow, rows[i].lamp);
    end
    $display("row tests done");
    // Filter saturates at its top and halves the step at setting 1
    wr(OFS_FILT, 16'h70);
    rchk("filter", OFS_FILT, 32'h63);
    wr(OFS_FILT, 16'h01);
    smp(16'h0);
    rchk("filtered", OFS_PV, 32'h74);
    wr(OFS_FILT, 16'h0);
    $display("filter test done");
    // Manual latch survives a short hold, clears on a full one
    wr(OFS_CFG1, 16'h0A);
    smp(16'hE8);
    smp(16'h20);
    chk("latched", relay_closed, 2'b01);
    keys(1'b1, 1'b0, 1'b1, HOLD - 1);
    chk("short hold", relay_closed, 2'b01);
    keys(1'b1, 1'b0, 1'b1, HOLD + 1);
    chk("acknowledged", relay_closed, 2'b00);
    $display("manual test done");
    // Inhibit re-armed from the keys holds off the first trip
    wr(OFS_CFG1, 16'h22);
    keys(1'b1, 1'b1, 1'b0, HOLD + 1);
    smp(16'hE8);
    chk("inhibited", relay_closed, 2'b00);
    smp(16'h20);
    smp(16'hE8);
    chk("inhibit lifted", relay_closed, 2'b01);
    $display("inhibit test done");
    // Power restore clears a manual latch once the condition is gone
    wr(OFS_CFG1, 16'h1A);
    smp(16'hE8);
    smp(16'h20);
    chk("latched", relay_closed, 2'b01);
    @(posedge clk);
    pwr <= 1'b1;
    @(posedge clk);
    pwr <= 1'b0;
    cyc(2);
    chk("restored", relay_closed, 2'b00);
    $display("restore test done");
    // Faults mask the alarms; only self check drops set points
    wr(OFS_CFG1, 16'h02);
    sp_req <= 2'b11;
    smp(16'hE8);
    chk("alarm", relay_closed, 2'b01);
    @(posedge clk);
    host_timeout_indication <= 1'b1;
    cyc(2);
    chk("timeout alarm", relay_closed, 2'b00);
    chk("timeout sp", setpoint_out, 2'b11);
    @(posedge clk);
    host_timeout_indication <= 1'b0;
    self_check_failure <= 1'b1;
    cyc(2);
    chk("fail alarm", relay_closed, 2'b00);
    chk("fail sp", setpoint_out, 2'b00);
    @(posedge clk);
    self_check_failure <= 1'b0;
    cyc(2);
    chk("recovered", relay_closed, 2'b01);
    $display("fault test done");
    // Mid-run reset drops the live alarm and restores the defaults
    @(posedge clk);
    nrst <= 1'b0;
    cyc(2);
    chk("reset contact", relay_closed, 2'b00);
    chk("reset lamp", lamp_glow, 2'b00);
    @(posedge clk);
    nrst <= 1'b1;
    cyc(3);
    rchk("filter", OFS_FILT, 32'h03);
    rchk("cfg1", OFS_CFG1, 32'h02);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule : dpau_core_tb
